// *** hw/aase_pkg.sv ***
// package for the and/skip execute slice: opcodes, widths, carriers
package aase_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [6:0] FADDR_RESET = 7'h00;

  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    AASE_OP_NONE = 3'h0,
    AASE_OP_AND_LITERAL = 3'h1,
    AASE_OP_AND_FILE = 3'h2,
    AASE_OP_TEST_SET = 3'h3,
    AASE_OP_TEST_CLEAR = 3'h4,
    AASE_OP_DEC_SKIP = 3'h5,
    AASE_OP_INC_SKIP = 3'h6
  } aase_op_t;

  // one decoded instruction
  typedef struct packed {
    logic valid;
    aase_op_t op;
    logic [7:0] literal;
    logic [6:0] faddr;
    logic [2:0] bit_sel;
    logic dest_file;
    logic [7:0] fdata;
  } aase_instr_t;

  // file register write-back
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } aase_fwrite_t;
endpackage : aase_pkg

// *** hw/aase_exec.sv ***
// execute slice for the and, bit-test skip and count-skip operations
//
// Behaviour
// - literal AND into accumulator, zero flag only
// - file AND, destination bit picks target, zero
// - bit set skips next, two cycles
// - bit clear skips next, two cycles
// - decrement file to chosen destination, flags kept
// - zero after decrement skips next instruction
// - increment file to chosen destination, flags kept
// - zero after increment skips next instruction
`timescale 1ns/10ps
module aase_exec #(
  parameter int DATA_WIDTH = aase_pkg::DATA_W, // operand and result width
  parameter int FADDR_WIDTH = aase_pkg::FADDR_W, // file register address width
  parameter int BIT_WIDTH = aase_pkg::BIT_W // tested-bit index width
) (
  input wire logic i_core_clk, // core instruction clock
  input wire logic i_rst, // synchronous reset, active high
  input wire aase_pkg::aase_instr_t i_instr, // instruction issued this cycle
  output logic [7:0] o_acc, // accumulator value
  output logic o_zero_flag, // zero flag
  output logic o_zero_we, // pulse: zero flag updated
  output aase_pkg::aase_fwrite_t o_fwrite, // file write-back, one cycle
  output logic o_retired, // pulse: instruction executed
  output logic o_no_operation, // pulse: a discarded slot ran as no-op
  output logic o_busy // high during the skip slot
);
  import aase_pkg::*;

  // the carriers are fixed width; the parameters may only repeat them
  if (DATA_WIDTH != DATA_W) begin : g_bad_data_width
    $error("operand width differs from the instruction carrier");
  end
  if (FADDR_WIDTH != FADDR_W) begin : g_bad_faddr_width
    $error("file address width differs from the write-back carrier");
  end
  if (BIT_WIDTH != BIT_W || (1 << BIT_WIDTH) != DATA_WIDTH) begin : g_bad_bit_width
    $error("bit index width cannot address every operand bit");
  end

  // one-hot slot state: run normally, or burn the slot after a skip
  typedef enum logic [1:0] {
    AASE_ST_RUN = 2'b01,
    AASE_ST_SKIP = 2'b10
  } aase_state_t;

  // all registered state of the slice
  typedef struct packed {
    aase_state_t st;
    logic [DATA_WIDTH-1:0] acc; // accumulator
    logic zero; // zero flag
    logic zero_we; // zero flag written last cycle
    aase_fwrite_t fw; // file write-back
    logic retired; // instruction executed
    logic no_operation; // discarded slot ran empty
    logic busy; // skip slot in progress
  } aase_s_t;

  // current and next state
  aase_s_t s_reg;
  aase_s_t s_next;

  // issue qualifier and per-operation strobes
  logic issue;
  logic op_and_lit;
  logic op_and_file;
  logic op_test_set;
  logic op_test_clear;
  logic op_dec;
  logic op_inc;
  logic op_any;
  logic op_from_file;
  logic to_file;

  // operands and results
  logic [DATA_WIDTH-1:0] fdata;
  logic [FADDR_WIDTH-1:0] faddr;
  logic [DATA_WIDTH-1:0] bit_hit;
  logic [DATA_WIDTH-1:0] and_lit_val;
  logic [DATA_WIDTH-1:0] and_file_val;
  logic [DATA_WIDTH-1:0] dec_val;
  logic [DATA_WIDTH-1:0] inc_val;
  logic [DATA_WIDTH-1:0] result;
  logic bit_val;
  logic skip;

  // an instruction counts only while the slot is not being skipped
  assign issue = i_instr.valid && (s_reg.st == AASE_ST_RUN);
  assign op_and_lit = issue && (i_instr.op == AASE_OP_AND_LITERAL);
  assign op_and_file = issue && (i_instr.op == AASE_OP_AND_FILE);
  assign op_test_set = issue && (i_instr.op == AASE_OP_TEST_SET);
  assign op_test_clear = issue && (i_instr.op == AASE_OP_TEST_CLEAR);
  assign op_dec = issue && (i_instr.op == AASE_OP_DEC_SKIP);
  assign op_inc = issue && (i_instr.op == AASE_OP_INC_SKIP);
  assign op_any = issue && (i_instr.op != AASE_OP_NONE);

  // destination select only applies to file-sourced results
  assign op_from_file = op_and_file || op_dec || op_inc;
  assign to_file = op_from_file && i_instr.dest_file;

  // operand copies at the parameter width
  assign fdata = i_instr.fdata;
  assign faddr = i_instr.faddr;

  // per-bit and products and tested-bit match
  for (genvar gi = 0; gi < DATA_WIDTH; gi++) begin : g_bit
    localparam logic [BIT_WIDTH-1:0] POS = BIT_WIDTH'(gi); // index of this bit
    assign and_lit_val[gi] = s_reg.acc[gi] & i_instr.literal[gi];
    assign and_file_val[gi] = s_reg.acc[gi] & fdata[gi];
    assign bit_hit[gi] = (i_instr.bit_sel == POS) && fdata[gi];
  end

  // selected bit of the file operand, at most one match is set
  assign bit_val = |bit_hit;

  // count results, wrapping through zero like any 8-bit counter
  assign dec_val = fdata - ONE;
  assign inc_val = fdata + ONE;

  // skip decision for the four conditional operations
  always_comb begin
    skip = 1'b0;
    if (op_test_set) begin
      skip = bit_val;
    end else if (op_test_clear) begin
      skip = !bit_val;
    end else if (op_dec) begin
      skip = (dec_val == '0);
    end else if (op_inc) begin
      skip = (inc_val == '0);
    end
  end

  // result of the file-sourced operations
  always_comb begin
    result = '0;
    if (op_and_file) begin
      result = and_file_val;
    end else if (op_dec) begin
      result = dec_val;
    end else if (op_inc) begin
      result = inc_val;
    end
  end

  // next state: pulses clear by default, the slot state decides the rest
  always_comb begin
    s_next = s_reg;
    s_next.zero_we = 1'b0;
    s_next.fw.en = 1'b0;
    s_next.retired = 1'b0;
    s_next.no_operation = 1'b0;
    s_next.busy = 1'b0;
    case (s_reg.st)
      AASE_ST_SKIP: begin
        // discarded instruction runs as a no-op
        s_next.no_operation = 1'b1;
        s_next.st = AASE_ST_RUN;
      end
      AASE_ST_RUN: begin
        if (op_any) begin
          s_next.retired = 1'b1;
        end
        if (op_and_lit) begin
          s_next.acc = and_lit_val;
          s_next.zero = (and_lit_val == '0);
          s_next.zero_we = 1'b1;
        end
        if (op_and_file) begin
          s_next.zero = (and_file_val == '0);
          s_next.zero_we = 1'b1;
        end
        // file-sourced result goes back to the file or the accumulator
        if (to_file) begin
          s_next.fw.en = 1'b1;
          s_next.fw.addr = faddr;
          s_next.fw.data = result;
        end else if (op_from_file) begin
          s_next.acc = result;
        end
        // a met condition burns the next slot, otherwise run on
        if (skip) begin
          s_next.st = AASE_ST_SKIP;
          s_next.busy = 1'b1;
        end else begin
          s_next.st = AASE_ST_RUN;
        end
      end
      default: begin
        s_next.st = AASE_ST_RUN;
      end
    endcase
  end

  // state register, synchronous reset to the idle slot
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg.st <= AASE_ST_RUN;
      s_reg.acc <= ACC_RESET;
      s_reg.zero <= 1'b0;
      s_reg.zero_we <= 1'b0;
      s_reg.fw.en <= 1'b0;
      s_reg.fw.addr <= FADDR_RESET;
      s_reg.fw.data <= 8'h00;
      s_reg.retired <= 1'b0;
      s_reg.no_operation <= 1'b0;
      s_reg.busy <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign o_acc = s_reg.acc;
  assign o_zero_flag = s_reg.zero;
  assign o_zero_we = s_reg.zero_we;
  assign o_fwrite = s_reg.fw;
  assign o_retired = s_reg.retired;
  assign o_no_operation = s_reg.no_operation;
  assign o_busy = s_reg.busy;
endmodule : aase_exec

// *** verification/aase_exec_properties.sv ***
// checker for the and/skip slice
`timescale 1ns/10ps
module aase_exec_properties (
  input wire logic i_core_clk, // clk
  input wire logic i_rst, // rst
  input wire aase_pkg::aase_instr_t i_instr, // instr
  input wire logic [7:0] o_acc, // acc
  input wire logic o_zero_flag, // z
  input wire logic o_zero_we, // z strobe
  input wire aase_pkg::aase_fwrite_t o_fwrite, // write
  input wire logic o_retired, // executed
  input wire logic o_no_operation, // no-op
  input wire logic o_busy // skip slot
);
  import aase_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // taken instruction, operands, tested bit
  wire tk = i_instr.valid && !o_busy;
  wire [2:0] op = i_instr.op;
  wire [7:0] fd = i_instr.fdata;
  wire [7:0] k = i_instr.literal;
  wire bt = fd[i_instr.bit_sel];
  a_and_lit: assert property (tk && op == 3'h1 |=> o_acc == ($past(o_acc) & $past(k)))
    else $error("and literal");
  a_and_zero: assert property (tk && op == 3'h1 |=> o_zero_we && o_zero_flag == !o_acc)
    else $error("zero flag");
  a_and_file: assert property (tk && op == 3'h2 && i_instr.dest_file
    |=> o_fwrite.en && o_fwrite.data == ($past(o_acc) & $past(fd))) else $error("file and");
  a_set_skip: assert property (tk && op == 3'h3 |=> o_busy == $past(bt))
    else $error("set skip");
  a_clr_skip: assert property (tk && op == 3'h4 |=> o_busy == !$past(bt))
    else $error("clear skip");
  a_count_flags: assert property (tk && op > 3'h4 |=> !o_zero_we)
    else $error("flag touched");
  a_dec_zero: assert property (tk && op == 3'h5 |=> o_busy == ($past(fd) == 8'h01))
    else $error("dec skip");
  a_inc_zero: assert property (tk && op == 3'h6 |=> o_busy == ($past(fd) == 8'hFF))
    else $error("inc skip");
  a_nop_slot: assert property (o_busy |=> o_no_operation && !o_busy)
    else $error("no-op slot");
  a_retire_once: assert property (tk && op != 3'h0 |=> o_retired)
    else $error("not retired");
  a_file_acc: assert property (tk && op == 3'h2 && !i_instr.dest_file
    |=> !o_fwrite.en && o_acc == ($past(o_acc) & $past(fd))) else $error("and to acc");
  a_dec_value: assert property (tk && op == 3'h5 && i_instr.dest_file
    |=> o_fwrite.en && o_fwrite.data == $past(fd) - 8'h01) else $error("dec value");
  a_inc_value: assert property (tk && op == 3'h6 && !i_instr.dest_file
    |=> o_acc == $past(fd) + 8'h01) else $error("inc value");
  c_nop: cover property (o_no_operation);
  c_file: cover property (o_fwrite.en);
  c_zero: cover property (o_zero_we && o_zero_flag);
endmodule : aase_exec_properties
bind aase_exec aase_exec_properties u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_instr(i_instr), .o_acc(o_acc), .o_zero_flag(o_zero_flag), .o_zero_we(o_zero_we),
  .o_fwrite(o_fwrite), .o_retired(o_retired), .o_no_operation(o_no_operation),
  .o_busy(o_busy));

// *** verification/aase_exec_tb.sv ***
// bench for the and/skip slice
`timescale 1ns/10ps
module aase_exec_tb;
  import aase_pkg::*;
  logic c = 1'b0;
  logic r = 1'b1;
  aase_instr_t in = '0;
  aase_fwrite_t w;
  logic [7:0] a;
  logic z, we, rt, n, b;
  int err_count = 0;
  int samples_checked = 0;
  aase_exec dut (.i_core_clk(c), .i_rst(r), .i_instr(in), .o_acc(a), .o_zero_flag(z),
    .o_zero_we(we), .o_fwrite(w), .o_retired(rt), .o_no_operation(n), .o_busy(b));
  initial forever #2.5 c = ~c;
  // hang guard
  initial begin
    repeat (400) @(posedge c);
    err_count++;
    conclude;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask : chk
  // one instruction, idle slot, settle; fdata mirrors k
  task go(input aase_op_t o, input logic [7:0] k, input logic [2:0] s, input logic d);
    @(posedge c) in <= '{1'b1, o, k, 7'h05, s, d, k};
    @(posedge c) in.valid <= 1'b0;
    #1;
  endtask : go
  task t_and;
    go(AASE_OP_INC_SKIP, 8'hEF, 3'h0, 1'b0);
    chk({b, a}, 16'h00F0);
    go(AASE_OP_AND_LITERAL, 8'h3C, 3'h0, 1'b0);
    chk({we, z, a}, 16'h0230);
    go(AASE_OP_AND_FILE, 8'hF3, 3'h0, 1'b0);
    chk({w.en, we, z, a}, 16'h0230);
    go(AASE_OP_AND_FILE, 8'h0F, 3'h0, 1'b1);
    chk(w, 16'h8500);
    chk({z, a}, 16'h0130);
  endtask : t_and
  task t_skip;
    @(posedge c) in <= '{1'b1, AASE_OP_TEST_SET, 8'h80, 7'h05, 3'h7, 1'b0, 8'h80};
    go(AASE_OP_AND_LITERAL, 8'h00, 3'h0, 1'b0);
    chk({n, b, a}, 16'h0230);
    go(AASE_OP_TEST_SET, 8'h7F, 3'h7, 1'b0);
    chk({rt, b}, 16'h0002);
    go(AASE_OP_TEST_CLEAR, 8'hFE, 3'h0, 1'b0);
    chk(b, 16'h0001);
    go(AASE_OP_TEST_CLEAR, 8'h01, 3'h0, 1'b0);
    chk(b, 16'h0000);
  endtask : t_skip
  task t_cnt;
    go(AASE_OP_DEC_SKIP, 8'h01, 3'h0, 1'b1);
    chk({b, we, w.data}, 16'h0200);
    go(AASE_OP_DEC_SKIP, 8'h05, 3'h0, 1'b0);
    chk({b, a}, 16'h0004);
    go(AASE_OP_INC_SKIP, 8'hFF, 3'h0, 1'b0);
    chk({b, z, a}, 16'h0300);
  endtask : t_cnt
  task conclude;
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // reset, scenarios, verdict
  initial begin
    repeat (2) @(posedge c);
    r <= 1'b0;
    t_and;
    t_skip;
    t_cnt;
    conclude;
  end
endmodule : aase_exec_tb
